/* File: core/fmo_pkg.sv */
// Constants for the fan and over-temperature output configuration block
package fmo_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] FMO_FAN_DIV_ADDR = 8'h05;
  localparam logic [7:0] FMO_OT_CFG_ADDR = 8'h06;

  // ****************************************
  // Fan divisor / pin select fields
  // ****************************************
  localparam int FMO_FAN_INPUT_ONE_MODE_BIT = 0;
  localparam int FMO_FAN_INPUT_TWO_MODE_BIT = 1;
  localparam int FMO_FAN_POL_BIT = 2;
  localparam int FMO_FAN_INPUT_ONE_DIV_LSB = 2;
  localparam int FMO_FAN_INPUT_TWO_DIV_LSB = 4;
  localparam int FMO_OT_EN_BIT = 6;
  localparam int FMO_RST_EN_BIT = 7;
  localparam logic [3:0] FMO_FAN_DIV_RST_HI = 4'h5;

  // ****************************************
  // Over-temperature configuration fields
  // ****************************************
  localparam int FMO_OT_STAT_BIT = 0;
  localparam int FMO_OT_POL_BIT = 1;
  localparam int FMO_OT_ONCE_BIT = 2;
  localparam int FMO_RES_BIT = 3;
  localparam int FMO_TFRAC_LSB = 4;
  localparam logic [7:0] FMO_OT_CFG_RST = 8'h01;
  localparam logic [7:0] FMO_OT_WR_MASK = 8'hFE;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint FMO_CLK_HZ = 20000000;
  localparam longint FMO_CONV8_MS = 100;
  localparam longint FMO_CONV11_MS = 2000;
  localparam longint FMO_CONV8_CYC = FMO_CONV8_MS * FMO_CLK_HZ / 1000;
  localparam longint FMO_CONV11_CYC = FMO_CONV11_MS * FMO_CLK_HZ / 1000;
  // Base fan counting tick, before the prescaler
  localparam logic [15:0] FMO_FAN_TICK_CYC = 16'h0379;

  // ****************************************
  // Shared pin function
  // ****************************************
  typedef enum logic [1:0] {
    FMO_PIN_OFF = 2'b00,
    FMO_PIN_OT = 2'b01,
    FMO_PIN_RST = 2'b10
  } fmo_pin_e;
endpackage

/* File: core/fmo_config_regs.sv */
// Fan divisor, shared pin select and over-temperature configuration registers
// Notes on behaviour
// - Bits 0 and 1 pick level alarm (one) or pulse counting (zero) per fan.
// - Bits 3:2 divide fan one counting by 1, 2, 4 or 8.
// - Bits 5:4 divide fan two counting by 1, 2, 4 or 8.
// - Bit 2 in level mode: one alarms on low input, zero on high.
// - Bit 6 set with bit 7 clear makes the shared pin the over-temperature output.
// - Bit 7 set makes the shared pin a reset output.
// - Bits 6 and 7 both clear leave the shared pin undriven.
// - Fan register powers up with 0101 above the four voltage id levels.
// - Over-temperature bit 0 is read-only, mirrors the pin in over-temperature mode.
// - Bit 1 picks over-temperature polarity; pin always open-drain.
// - Bit 2 picks one-time interrupt mode (one) or comparator mode (zero).
// - Bit 3 picks 8-bit (about 100 ms) or 11-bit (about 2 s) conversions.
// - In 11-bit mode bits 7:4 hold the four low temperature bits.
// - In 8-bit mode bit 7 holds the 0.5 degree bit; bits 6:4 undefined.
// - Over-temperature register powers up as 0000 0001.
// - Fan reading counts prescaled clock ticks over one fan revolution.
`timescale 1ns/1ps
module fmo_config_regs
  import fmo_pkg::*;
#(
  parameter longint CONV8_CYCLES = FMO_CONV8_CYC,
  parameter longint CONV11_CYCLES = FMO_CONV11_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [3:0] voltage_id_inputs_in,
  input wire logic fan_input_one_in,
  input wire logic fan_input_two_in,
  output logic [1:0] fan_alarm_out,
  output logic [7:0] fan_reading_one_out,
  output logic [7:0] fan_reading_two_out,
  input wire logic overtemp_hot_in,
  input wire logic overtemp_ack_in,
  input wire logic reset_req_in,
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe_out,
  input wire logic [3:0] temp_frac_in,
  input wire logic temp_load_in,
  output logic conv_done_out,
  output logic high_res_out
);

  // ****************************************
  // Register access
  // ****************************************
  logic [7:0] fan_div_q, fan_div_d;
  logic [7:0] ot_cfg_q, ot_cfg_d;
  logic vid_load_q, vid_load_d;
  logic [7:0] rdata_q, rdata_d;
  logic ot_active_q, ot_active_d;
  logic hot_prev_q, hot_prev_d;
  logic pin_oe_q, pin_oe_d;
  fmo_pin_e pin_mode;

  function automatic fmo_pin_e pin_func(input logic [7:0] cfg);
    if (cfg[FMO_RST_EN_BIT]) begin
      pin_func = FMO_PIN_RST;
    end else if (cfg[FMO_OT_EN_BIT]) begin
      pin_func = FMO_PIN_OT;
    end else begin
      pin_func = FMO_PIN_OFF;
    end
  endfunction

  assign pin_mode = pin_func(fan_div_q);

  always_comb begin
    fan_div_d = fan_div_q;
    ot_cfg_d = ot_cfg_q;
    vid_load_d = 1'b0;
    rdata_d = rdata_q;
    // Straps are caught on the first edge after release, not under reset
    if (vid_load_q) begin
      fan_div_d = {FMO_FAN_DIV_RST_HI, voltage_id_inputs_in};
    end
    if (temp_load_in) begin
      if (ot_cfg_q[FMO_RES_BIT]) begin
        ot_cfg_d[7:4] = temp_frac_in;
      end else begin
        // Undefined low bits are simply cleared
        ot_cfg_d[7:4] = {temp_frac_in[3], 3'b000};
      end
    end
    // Host write comes after the load, so it wins on bits 7:4
    if (reg_wr_in) begin
      if (reg_addr_in == FMO_FAN_DIV_ADDR) begin
        fan_div_d = reg_wdata_in;
      end else if (reg_addr_in == FMO_OT_CFG_ADDR) begin
        ot_cfg_d = (reg_wdata_in & FMO_OT_WR_MASK) | (ot_cfg_d & ~FMO_OT_WR_MASK);
      end
    end
    // Status bit tracks the pin level while in over-temperature mode
    if (pin_mode == FMO_PIN_OT) begin
      ot_cfg_d[FMO_OT_STAT_BIT] = shared_pin_in;
    end
    if (reg_rd_in) begin
      if (reg_addr_in == FMO_FAN_DIV_ADDR) begin
        rdata_d = fan_div_q;
      end else if (reg_addr_in == FMO_OT_CFG_ADDR) begin
        rdata_d = ot_cfg_q;
      end else begin
        // Unmapped addresses read as zero
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fan_div_q <= {FMO_FAN_DIV_RST_HI, 4'h0};
      ot_cfg_q <= FMO_OT_CFG_RST;
      vid_load_q <= 1'b1;
      rdata_q <= 8'h00;
    end else begin
      fan_div_q <= fan_div_d;
      ot_cfg_q <= ot_cfg_d;
      vid_load_q <= vid_load_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ****************************************
  // Shared reset / over-temperature pin
  // ****************************************
  always_comb begin
    ot_active_d = ot_active_q;
    // Edge detect starts low; reset selects comparator mode, so no false edge
    hot_prev_d = overtemp_hot_in;
    // An event held over from comparator mode stays latched until acknowledged
    if (ot_cfg_q[FMO_OT_ONCE_BIT]) begin
      // One-time: latch on the rising edge, held until acknowledged
      if (overtemp_hot_in && !hot_prev_q) begin
        ot_active_d = 1'b1;
      end else if (overtemp_ack_in) begin
        ot_active_d = 1'b0;
      end
    end else begin
      ot_active_d = overtemp_hot_in;
    end
    // Open-drain: only ever pulls low, never drives high
    case (pin_mode)
      FMO_PIN_RST: pin_oe_d = reset_req_in;
      FMO_PIN_OT: pin_oe_d = ot_active_d ^ ot_cfg_q[FMO_OT_POL_BIT];
      default: pin_oe_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ot_active_q <= 1'b0;
      hot_prev_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      ot_active_q <= ot_active_d;
      hot_prev_q <= hot_prev_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  // High level comes from the board pull-up only
  assign shared_pin_out = 1'b0;
  assign shared_pin_oe_out = pin_oe_q;

  // ****************************************
  // Conversion timing
  // ****************************************
  // Wide enough for the slow conversion period at the full clock rate
  logic [31:0] conv_cnt_q, conv_cnt_d;
  logic conv_done_q, conv_done_d;
  logic high_res_q;

  always_comb begin
    conv_cnt_d = conv_cnt_q + 32'h0000_0001;
    conv_done_d = 1'b0;
    // A mode change restarts the current conversion
    if (high_res_q != ot_cfg_q[FMO_RES_BIT]) begin
      conv_cnt_d = 32'h0000_0000;
    end else if ((!high_res_q && conv_cnt_q >= 32'(CONV8_CYCLES - 1)) ||
                 (high_res_q && conv_cnt_q >= 32'(CONV11_CYCLES - 1))) begin
      conv_cnt_d = 32'h0000_0000;
      conv_done_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_cnt_q <= 32'h0000_0000;
      conv_done_q <= 1'b0;
      high_res_q <= 1'b0;
    end else begin
      conv_cnt_q <= conv_cnt_d;
      conv_done_q <= conv_done_d;
      high_res_q <= ot_cfg_q[FMO_RES_BIT];
    end
  end

  assign conv_done_out = conv_done_q;
  assign high_res_out = high_res_q;

  // ****************************************
  // Fan inputs: level alarm or pulse counting
  // ****************************************
  logic [1:0] fan_in;
  logic [1:0] fan_mode;
  logic [1:0][1:0] fan_div;
  logic [1:0][7:0] fan_reading;
  logic [15:0] tick_cnt_q, tick_cnt_d;
  logic tick;

  assign fan_in = {fan_input_two_in, fan_input_one_in};
  assign fan_mode = {fan_div_q[FMO_FAN_INPUT_TWO_MODE_BIT], fan_div_q[FMO_FAN_INPUT_ONE_MODE_BIT]};
  assign fan_div[0] = fan_div_q[FMO_FAN_INPUT_ONE_DIV_LSB +: 2];
  assign fan_div[1] = fan_div_q[FMO_FAN_INPUT_TWO_DIV_LSB +: 2];
  assign tick = (tick_cnt_q == FMO_FAN_TICK_CYC - 16'h0001);

  always_comb begin
    tick_cnt_d = tick_cnt_q + 16'h0001;
    if (tick) begin
      tick_cnt_d = 16'h0000;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_fan
    logic [2:0] pre_q, pre_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] rd_q, rd_d;
    logic prev_q;
    logic alarm_q, alarm_d;
    logic [2:0] pre_top;

    // Divide by 1, 2, 4 or 8
    assign pre_top = 3'((4'h1 << fan_div[g]) - 4'h1);

    always_comb begin
      pre_d = pre_q;
      cnt_d = cnt_q;
      rd_d = rd_q;
      // Level mode: bit 2 set means the alarm is raised on a low input
      alarm_d = fan_mode[g] & (fan_in[g] ^ fan_div_q[FMO_FAN_POL_BIT]);
      if (fan_mode[g]) begin
        pre_d = 3'h0;
        cnt_d = 8'h00;
      end else if (fan_in[g] && !prev_q) begin
        rd_d = cnt_q;
        cnt_d = 8'h00;
        pre_d = 3'h0;
      end else if (tick) begin
        if (pre_q >= pre_top) begin
          pre_d = 3'h0;
          // Saturates so a fan slower than the count range reads as all ones at its next edge; a stopped fan keeps its last reading
          if (cnt_q != 8'hFF) begin
            cnt_d = cnt_q + 8'h01;
          end
        end else begin
          pre_d = pre_q + 3'h1;
        end
      end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
        pre_q <= 3'h0;
        cnt_q <= 8'h00;
        rd_q <= 8'h00;
        prev_q <= 1'b0;
        alarm_q <= 1'b0;
      end else begin
        pre_q <= pre_d;
        cnt_q <= cnt_d;
        rd_q <= rd_d;
        prev_q <= fan_in[g];
        alarm_q <= alarm_d;
      end
    end

    assign fan_alarm_out[g] = alarm_q;
    assign fan_reading[g] = rd_q;
  end

  assign fan_reading_one_out = fan_reading[0];
  assign fan_reading_two_out = fan_reading[1];

endmodule

/* File: tb/fmo_pin_pullup.sv */
// Open-drain load on the shared pin: pull-up resistor plus wire
`timescale 1ns/1ps
module fmo_pin_pullup (
  input wire logic oe_in,
  input wire logic drv_in,
  output logic pin_out
);
  // Released pin floats up, never keeps the last driven level
  assign pin_out = oe_in ? drv_in : 1'b1;
endmodule

/* File: tb/fmo_config_regs_properties.sv */
// Port checker for the configuration register block
`timescale 1ns/1ps
module fmo_config_regs_chk
  import fmo_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic overtemp_hot_in,
  input wire logic overtemp_ack_in,
  input wire logic reset_req_in,
  input wire logic shared_pin_in,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe_out,
  input wire logic [3:0] temp_frac_in,
  input wire logic temp_load_in,
  input wire logic conv_done_out,
  input wire logic high_res_out
);
  // ****************************************
  // Shadow of pin mode and over-temp fields
  // ****************************************
  logic [1:0] mode_q, mode_d, ot_q, ot_d;
  logic res_q, res_d;
  wire w5 = reg_wr_in && reg_addr_in == FMO_FAN_DIV_ADDR;
  wire w6 = reg_wr_in && reg_addr_in == FMO_OT_CFG_ADDR;
  wire r5 = reg_rd_in && reg_addr_in == FMO_FAN_DIV_ADDR;
  wire r6 = reg_rd_in && reg_addr_in == FMO_OT_CFG_ADDR;
  always_comb begin
    mode_d = w5 ? reg_wdata_in[7:6] : mode_q;
    ot_d = w6 ? reg_wdata_in[2:1] : ot_q;
    res_d = w6 ? reg_wdata_in[3] : res_q;
  end
  // Reset value 0x50 leaves the pin in over-temp mode
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= 2'b01;
      ot_q <= 2'b00;
      res_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      ot_q <= ot_d;
      res_q <= res_d;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence wr_rd5;
    w5 ##1 !w5 ##1 r5;
  endsequence
  sequence load_rd6;
    (temp_load_in && !w6) ##1 (!temp_load_in && !w6) ##1 (r6 && !temp_load_in && !w6);
  endsequence
  wr_read_back_a: assert property (wr_rd5 |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("fan register read back differs");
  frac_load_a: assert property ((res_q ##0 load_rd6) |=> reg_rdata_out[7:4] == $past(temp_frac_in, 3))
    else $error("temperature nibble not loaded");
  frac_half_a: assert property ((!res_q ##0 load_rd6) |=> reg_rdata_out[7] == $past(temp_frac_in[3], 3))
    else $error("half degree bit not loaded");
  res_echo_a: assert property (w6 |=> ##1 high_res_out == $past(reg_wdata_in[3], 2))
    else $error("resolution output wrong");
  pin_off_a: assert property (mode_q == 2'b00 |=> !shared_pin_oe_out)
    else $error("disabled pin driven");
  reset_mode_a: assert property (mode_q[1] |=> shared_pin_oe_out == $past(reset_req_in))
    else $error("reset output wrong");
  ot_comp_a: assert property (mode_q == 2'b01 && !ot_q[1] |=>
    shared_pin_oe_out == ($past(overtemp_hot_in) ^ $past(ot_q[0])))
    else $error("comparator output wrong");
  ot_once_a: assert property (mode_q == 2'b01 && ot_q[1] && $rose(overtemp_hot_in) && !overtemp_ack_in
    |=> ##[0:1] shared_pin_oe_out != $past(ot_q[0]))
    else $error("one-time event missed");
  status_mirror_a: assert property (mode_q == 2'b01 ##1 (mode_q == 2'b01 && r6)
    |=> reg_rdata_out[0] == $past(shared_pin_in, 2))
    else $error("status bit not mirroring pin");
  open_drain_a: assert property (shared_pin_out == 1'b0)
    else $error("pin driven high");
  conv_pulse_a: assert property (conv_done_out |=> !conv_done_out)
    else $error("conversion pulse too long");
endmodule
bind fmo_config_regs fmo_config_regs_chk u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .overtemp_hot_in(overtemp_hot_in), .overtemp_ack_in(overtemp_ack_in),
  .reset_req_in(reset_req_in), .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
  .shared_pin_oe_out(shared_pin_oe_out), .temp_frac_in(temp_frac_in), .temp_load_in(temp_load_in),
  .conv_done_out(conv_done_out), .high_res_out(high_res_out));

/* File: tb/fmo_config_regs_tb.sv */
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
module fmo_config_regs_tb;
  import fmo_pkg::*;
  localparam int FAN_P = 16 * FMO_FAN_TICK_CYC;
  logic mclk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, fan_one = 0, fan_two = 0;
  logic overtemp_hot_in = 0, overtemp_ack_in = 0, reset_req_in = 0, temp_load_in = 0;
  logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, rd1, rd2;
  logic [3:0] temp_frac_in = 0;
  logic [3:0] voltage_id_inputs = 4'hA;
  logic [1:0] fan_alarm_out;
  logic shared_pin_in, shared_pin_out, shared_pin_oe_out, conv_done_out, high_res_out;
  int num_errors = 0, comparisons = 0;
  always #25 mclk_in = ~mclk_in;
  fmo_config_regs #(.CONV8_CYCLES(20), .CONV11_CYCLES(50)) uut (.mclk_in(mclk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .voltage_id_inputs_in(voltage_id_inputs), .fan_input_one_in(fan_one),
    .fan_input_two_in(fan_two), .fan_alarm_out(fan_alarm_out), .fan_reading_one_out(rd1),
    .fan_reading_two_out(rd2), .overtemp_hot_in(overtemp_hot_in), .overtemp_ack_in(overtemp_ack_in),
    .reset_req_in(reset_req_in), .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
    .shared_pin_oe_out(shared_pin_oe_out), .temp_frac_in(temp_frac_in), .temp_load_in(temp_load_in),
    .conv_done_out(conv_done_out), .high_res_out(high_res_out));
  fmo_pin_pullup u_pin (.oe_in(shared_pin_oe_out), .drv_in(shared_pin_out), .pin_out(shared_pin_in));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 chk("rdata", e, reg_rdata_out & m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic ld(input logic [3:0] f);
    @(posedge mclk_in);
    temp_frac_in <= f;
    temp_load_in <= 1'b1;
    @(posedge mclk_in);
    temp_load_in <= 1'b0;
  endtask
  // Period between two conversion pulses, sampled on the quiet edge
  task automatic conv(input int e);
    int n;
    n = 0;
    while (conv_done_out !== 1'b1 && n < 200) begin
      @(negedge mclk_in);
      n++;
    end
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (conv_done_out !== 1'b1 && n < 200);
    chk("conv_period", 8'(e), 8'(n));
  endtask
  task automatic near(input string n, input int e, input logic [7:0] g);
    comparisons++;
    if ($isunknown(g) || int'(g) < e - 1 || int'(g) > e + 1) begin
      num_errors++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #4000000;
    num_errors++;
    end_of_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    cyc(3);
    rst_in <= 1'b0;
    cyc(1);
    rd(FMO_FAN_DIV_ADDR, 8'hFF, 8'h5A);
    rd(FMO_OT_CFG_ADDR, 8'hFF, 8'h01);
    rd(8'h07, 8'hFF, 8'h00);
    wr(FMO_OT_CFG_ADDR, 8'h00);
    rd(FMO_OT_CFG_ADDR, 8'hFF, 8'h01);
    reset_req_in <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(FMO_FAN_DIV_ADDR, {m[1:0], 6'h2A});
      rd(FMO_FAN_DIV_ADDR, 8'hFF, {m[1:0], 6'h2A});
      cyc(2);
      #1 chk("pin_oe", 8'(m[1]), 8'(shared_pin_oe_out));
    end
    reset_req_in <= 1'b0;
    wr(FMO_FAN_DIV_ADDR, 8'h40);
    overtemp_hot_in <= 1'b1;
    cyc(2);
    rd(FMO_OT_CFG_ADDR, 8'h01, 8'h00);
    chk("pin_oe", 8'h01, 8'(shared_pin_oe_out));
    wr(FMO_OT_CFG_ADDR, 8'h02);
    cyc(2);
    #1 chk("pin_oe", 8'h00, 8'(shared_pin_oe_out));
    wr(FMO_OT_CFG_ADDR, 8'h04);
    overtemp_hot_in <= 1'b0;
    // Clear the event carried over from comparator mode first
    @(posedge mclk_in) overtemp_ack_in <= 1'b1;
    @(posedge mclk_in) overtemp_ack_in <= 1'b0;
    cyc(2);
    #1 chk("pin_oe", 8'h00, 8'(shared_pin_oe_out));
    cyc(2);
    overtemp_hot_in <= 1'b1;
    cyc(2);
    overtemp_hot_in <= 1'b0;
    cyc(3);
    #1 chk("pin_oe", 8'h01, 8'(shared_pin_oe_out));
    @(posedge mclk_in) overtemp_ack_in <= 1'b1;
    @(posedge mclk_in) overtemp_ack_in <= 1'b0;
    cyc(3);
    #1 chk("pin_oe", 8'h00, 8'(shared_pin_oe_out));
    wr(FMO_FAN_DIV_ADDR, 8'h03);
    fan_two <= 1'b1;
    cyc(3);
    #1 chk("fan_alarm", 8'h02, 8'(fan_alarm_out));
    wr(FMO_FAN_DIV_ADDR, 8'h07);
    cyc(3);
    #1 chk("fan_alarm", 8'h01, 8'(fan_alarm_out));
    wr(FMO_OT_CFG_ADDR, 8'h0E);
    rd(FMO_OT_CFG_ADDR, 8'h0E, 8'h0E);
    chk("high_res", 8'h01, 8'(high_res_out));
    conv(50);
    ld(4'h9);
    rd(FMO_OT_CFG_ADDR, 8'hF0, 8'h90);
    wr(FMO_OT_CFG_ADDR, 8'h00);
    conv(20);
    ld(4'hE);
    rd(FMO_OT_CFG_ADDR, 8'h80, 8'h80);
    // Fan one divides by eight, fan two by two
    wr(FMO_FAN_DIV_ADDR, 8'h1C);
    for (int i = 0; i < 3; i++) begin
      fan_one <= 1'b1;
      fan_two <= 1'b1;
      cyc(FAN_P / 2);
      fan_one <= 1'b0;
      fan_two <= 1'b0;
      cyc(FAN_P / 2);
    end
    near("fan_one", 2, rd1);
    near("fan_two", 8, rd2);
    // Second reset with other strap levels
    voltage_id_inputs <= 4'h3;
    rst_in <= 1'b1;
    cyc(3);
    rst_in <= 1'b0;
    cyc(1);
    rd(FMO_FAN_DIV_ADDR, 8'hFF, 8'h53);
    rd(FMO_OT_CFG_ADDR, 8'hFF, 8'h01);
    end_of_test();
  end
endmodule
